// >>> spm_pkg.sv
// Package holding register map, field layout, defaults and timing for the monitor.
package spm_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 3;
  // Register indices on the register port.
  localparam logic [2:0] ADDR_SETUP = 3'h0;
  localparam logic [2:0] ADDR_SHUNT = 3'h1;
  localparam logic [2:0] ADDR_RAIL = 3'h2;
  localparam logic [2:0] ADDR_POWER = 3'h3;
  localparam logic [2:0] ADDR_CURRENT = 3'h4;
  localparam logic [2:0] ADDR_SCALE = 3'h5;
  localparam logic [2:0] ADDR_ALERT_SEL = 3'h6;
  localparam logic [2:0] ADDR_THRESH = 3'h7;
  // Default values after power-up.
  localparam logic [15:0] SETUP_RESET = 16'h4127;
  localparam logic [15:0] SCALE_RESET = 16'h0000;
  localparam logic [15:0] ALERT_SEL_RESET = 16'h0000;
  localparam logic [15:0] THRESH_RESET = 16'h0000;
  // Setup field layout: averaging, rail time, shunt time, mode.
  localparam int AVG_LSB = 9;
  localparam int RAIL_CT_LSB = 6;
  localparam int SHUNT_CT_LSB = 3;
  localparam int CT_W = 3;
  localparam int RANGE_BIT = 12;
  localparam int RESET_BIT = 15;
  // Alert select enables, then the two status flags read back.
  localparam int SHUNT_OVER_EN_BIT = 15;
  localparam int SHUNT_UNDER_EN_BIT = 14;
  localparam int RAIL_OVER_EN_BIT = 13;
  localparam int RAIL_UNDER_EN_BIT = 12;
  localparam int POWER_OVER_EN_BIT = 11;
  localparam int READY_EN_BIT = 10;
  localparam int TRIP_FLAG_BIT = 4;
  localparam int READY_FLAG_BIT = 3;
  // Current scaling shift: cal * shunt / 2048.
  localparam int CAL_SHIFT = 11;
  // Power step is 32 current steps; 625 rail counts of 1.6 mV make 1 V.
  localparam int POWER_DIV = 32;
  localparam int RAIL_POWER_DIV = 625;
  // Base conversion tick: 1 us at a 10 MHz clock.
  localparam int CLK_MHZ = 10;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  // Conversion times in microseconds for codes 0 to 7.
  localparam logic [13:0] CONV_US_0 = 14'h008c;
  localparam logic [13:0] CONV_US_1 = 14'h00cc;
  localparam logic [13:0] CONV_US_2 = 14'h014c;
  localparam logic [13:0] CONV_US_3 = 14'h024c;
  localparam logic [13:0] CONV_US_4 = 14'h044c;
  localparam logic [13:0] CONV_US_5 = 14'h0844;
  localparam logic [13:0] CONV_US_6 = 14'h103c;
  localparam logic [13:0] CONV_US_7 = 14'h2034;
  localparam logic [15:0] FULL_SCALE_UV_X100 = 16'h2000; // 81.92 mV range.
endpackage

// >>> spm_conv_timer.sv
// Conversion timer: counts the selected conversion time in microsecond ticks.
`timescale 1ns/1ns
module spm_conv_timer
  import spm_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset.
  input wire logic tick, // One-microsecond enable.
  input wire logic start, // Begin a new timed phase.
  input wire logic [2:0] ct_sel, // Conversion time code.
  output logic done // One-cycle pulse at end of phase.
);
  logic [13:0] cnt_reg;
  logic busy_reg;
  logic [13:0] limit;

  // Conversion times 140 us up to 8244 us, coded 0 to 7.
  always_comb begin
    unique case (ct_sel)
      3'h0: limit = CONV_US_0;
      3'h1: limit = CONV_US_1;
      3'h2: limit = CONV_US_2;
      3'h3: limit = CONV_US_3;
      3'h4: limit = CONV_US_4;
      3'h5: limit = CONV_US_5;
      3'h6: limit = CONV_US_6;
      3'h7: limit = CONV_US_7;
    endcase
  end

  // Counter runs only on tick, so a phase lasts the chosen time.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 14'h0000;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= 14'h0000;
        busy_reg <= 1'b1;
      end else if (busy_reg && tick) begin
        if (cnt_reg == limit - 14'd1) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 14'd1;
        end
      end
    end
  end
endmodule

// >>> spm_avg.sv
// Accumulator that averages a signed sample stream over a power-of-two count.
`timescale 1ns/1ns
module spm_avg
  import spm_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset.
  input wire logic clear, // Start a new average.
  input wire logic add, // Accumulate sample this cycle.
  input wire logic [15:0] sample, // Signed sample.
  input wire logic [3:0] shift, // log2 of the averaging count.
  output logic [15:0] mean // Signed mean of accumulated samples.
);
  logic signed [25:0] acc_reg;

  // Sign-extended accumulation; ten extra bits cover 1024 samples.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= '0;
    end else if (clear) begin
      acc_reg <= '0;
    end else if (add) begin
      acc_reg <= acc_reg + 26'(signed'(sample));
    end
  end

  assign mean = 16'(acc_reg >>> shift);
endmodule

// >>> spm_monitor.sv
// Register file, conversion sequencer, result scaling and alert for monitor.
// How it works
// - Powers up on the 81.92 mV range, converting shunt and rail continuously.
// - Calibration left at zero forces current and power results to zero.
// - Shunt, rail results and their limit compares never depend on calibration; the power compare does.
// - Alert-select register chooses which condition may drive the alert.
// - Alert threshold register holds the trip level the host programs.
// - Shunt-over-limit enable compares shunt voltage against the threshold.
// - Shunt limits use the 2.5 uV shunt step.
// - Threshold returns to default on every reset.
// - Shunt 2.5 uV, rail 1.6 mV, current calibrated step, all linear.
// - Power step equals 32 current steps.
// - Shunt and current results are signed two's complement.
// - Alert follows a fault within one to two conversions.
// - Results readable at offsets 1 to 4.
// - Setup selects shunt time, rail time, averaging independently.
`timescale 1ns/1ns
module spm_monitor
  import spm_pkg::*;
(
  input wire logic clk, // System clock, 10 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [2:0] reg_addr, // Register index.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [15:0] reg_wdata, // Write data.
  output logic [15:0] reg_rdata, // Read data, valid cycle after reg_rd.
  input wire logic [15:0] adc_shunt, // Signed shunt sample, 2.5 uV steps.
  input wire logic [15:0] adc_rail, // Rail sample, 1.6 mV steps.
  output logic alert_n // Alert output, active low.
);
  typedef enum logic [1:0] {
    SPM_IDLE = 2'b00,
    SPM_SHUNT = 2'b01,
    SPM_RAIL = 2'b10,
    SPM_DONE = 2'b11
  } spm_state_t;

  spm_state_t state_reg;
  logic [15:0] setup_control_reg;
  logic [15:0] scale_factor_reg;
  logic [15:0] alert_select_flags_reg;
  logic [15:0] alert_threshold_reg;
  logic [15:0] shunt_reg;
  logic [15:0] rail_reg;
  logic [15:0] current_reg;
  logic [15:0] power_reg;
  logic trip_flag_reg;
  logic ready_flag_reg;
  logic shunt_over_limit_enable;
  logic ready_alert_enable;
  logic [3:0] tick_cnt_reg;
  logic tick_reg;
  logic [10:0] avg_cnt_reg;
  logic start_reg;
  logic timer_done;
  logic [2:0] ct_sel;
  logic [3:0] avg_shift;
  logic [10:0] avg_total;
  logic [15:0] shunt_mean;
  logic [15:0] rail_mean;
  logic signed [31:0] cur_prod;
  logic signed [15:0] cur_val;
  logic signed [31:0] pow_prod;
  logic [15:0] pow_val;
  logic trip;
  logic setup_wr;

  assign setup_wr = reg_wr && (reg_addr == ADDR_SETUP);
  // Named enables keep the alert logic readable against the register map.
  assign shunt_over_limit_enable =
    alert_select_flags_reg[SHUNT_OVER_EN_BIT];
  assign ready_alert_enable = alert_select_flags_reg[READY_EN_BIT];

  // Microsecond tick from the system clock. An enable pulse rather than
  // a divided clock keeps the whole block in one clock domain.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 4'(TICK_CYC - 1));
      if (tick_cnt_reg == 4'(TICK_CYC - 1)) begin
        tick_cnt_reg <= 4'h0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
      end
    end
  end

  // Averaging count codes 0..7 map to 1,4,16,64,128,256,512,1024.
  always_comb begin
    unique case (setup_control_reg[AVG_LSB +: CT_W])
      3'h0: avg_shift = 4'd0;
      3'h1: avg_shift = 4'd2;
      3'h2: avg_shift = 4'd4;
      3'h3: avg_shift = 4'd6;
      3'h4: avg_shift = 4'd7;
      3'h5: avg_shift = 4'd8;
      3'h6: avg_shift = 4'd9;
      3'h7: avg_shift = 4'd10;
    endcase
    avg_total = 11'(1) << avg_shift;
  end

  // Each phase uses its own time field, so both are set apart.
  assign ct_sel = (state_reg == SPM_RAIL) ?
    setup_control_reg[RAIL_CT_LSB +: CT_W] :
    setup_control_reg[SHUNT_CT_LSB +: CT_W];

  spm_conv_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_reg),
    .start(start_reg),
    .ct_sel(ct_sel),
    .done(timer_done)
  );

  spm_avg u_avg_shunt (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(state_reg == SPM_IDLE),
    .add(timer_done && state_reg == SPM_SHUNT),
    .sample(adc_shunt),
    .shift(avg_shift),
    .mean(shunt_mean)
  );

  spm_avg u_avg_rail (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(state_reg == SPM_IDLE),
    .add(timer_done && state_reg == SPM_RAIL),
    .sample(adc_rail),
    .shift(avg_shift),
    .mean(rail_mean)
  );

  // Sequencer: shunt then rail per sample, repeated over the average.
  // It free-runs from reset, so no host setup is needed to convert.
  // A setup write restarts the average so new times take effect cleanly.
  // Samples are taken at the end of each phase, not at its start.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SPM_IDLE;
      start_reg <= 1'b0;
      avg_cnt_reg <= 11'h000;
    end else begin
      start_reg <= 1'b0;
      if (setup_wr) begin
        state_reg <= SPM_IDLE;
      end else begin
        unique case (state_reg)
          SPM_IDLE: begin
            avg_cnt_reg <= 11'h000;
            start_reg <= 1'b1;
            state_reg <= SPM_SHUNT;
          end
          SPM_SHUNT: begin
            if (timer_done) begin
              start_reg <= 1'b1;
              state_reg <= SPM_RAIL;
            end
          end
          SPM_RAIL: begin
            if (timer_done) begin
              if (avg_cnt_reg == avg_total - 11'h001) begin
                state_reg <= SPM_DONE;
              end else begin
                avg_cnt_reg <= avg_cnt_reg + 11'h001;
                start_reg <= 1'b1;
                state_reg <= SPM_SHUNT;
              end
            end
          end
          SPM_DONE: begin
            state_reg <= SPM_IDLE;
          end
        endcase
      end
    end
  end

  // Current is shunt times calibration over 2048; zero calibration gives 0.
  // The calibration factor is positive, so current keeps the shunt sign.
  assign cur_prod = 32'(signed'(shunt_mean)) *
    32'(signed'({1'b0, scale_factor_reg[14:0]}));
  assign cur_val = 16'(cur_prod >>> CAL_SHIFT);
  // Power is current times rail scaled so one count is 32 current steps.
  // Current counts times rail counts of 1.6 mV give power in current
  // steps over 625; dividing by 32 more lands on the power step.
  // The magnitude is taken first, so power never reads as negative.
  assign pow_prod = 32'(cur_val) * 32'(signed'({1'b0, rail_mean[14:0]}));
  assign pow_val = 16'((pow_prod < 0 ? -pow_prod : pow_prod) /
    (POWER_DIV * RAIL_POWER_DIV));

  // Result registers load at the end of each averaged conversion.
  // They hold between conversions, so a read never sees a half update.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shunt_reg <= 16'h0000;
      rail_reg <= 16'h0000;
      current_reg <= 16'h0000;
      power_reg <= 16'h0000;
    end else if (state_reg == SPM_DONE) begin
      shunt_reg <= shunt_mean;
      rail_reg <= {1'b0, rail_mean[14:0]};
      current_reg <= 16'(cur_val);
      power_reg <= pow_val;
    end
  end

  // Shunt and rail compares use raw results, never the calibration value.
  // The power compare needs calibration, like the power result itself.
  always_comb begin
    trip = 1'b0;
    if (shunt_over_limit_enable &&
        $signed(shunt_mean) > $signed(alert_threshold_reg)) begin
      trip = 1'b1;
    end
    if (alert_select_flags_reg[SHUNT_UNDER_EN_BIT] &&
        $signed(shunt_mean) < $signed(alert_threshold_reg)) begin
      trip = 1'b1;
    end
    if (alert_select_flags_reg[RAIL_OVER_EN_BIT] &&
        rail_mean > alert_threshold_reg) begin
      trip = 1'b1;
    end
    if (alert_select_flags_reg[RAIL_UNDER_EN_BIT] &&
        rail_mean < alert_threshold_reg) begin
      trip = 1'b1;
    end
    if (alert_select_flags_reg[POWER_OVER_EN_BIT] &&
        pow_val > alert_threshold_reg) begin
      trip = 1'b1;
    end
  end

  // Alert evaluated once per completed conversion, so it lands within
  // one to two conversions of a fault. Reading the select register
  // clears the ready flag, but a conversion ending that cycle wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_flag_reg <= 1'b0;
      ready_flag_reg <= 1'b0;
      alert_n <= 1'b1;
    end else begin
      if (state_reg == SPM_DONE) begin
        trip_flag_reg <= trip;
        ready_flag_reg <= 1'b1;
        alert_n <= ~(trip || ready_alert_enable);
      end else if (reg_rd && reg_addr == ADDR_ALERT_SEL) begin
        ready_flag_reg <= 1'b0;
        // The read releases only the ready part of the alert; a tripped
        // limit keeps the pin low until a conversion clears it.
        if (ready_alert_enable) begin
          alert_n <= ~trip_flag_reg;
        end
      end
    end
  end

  // Host-writable registers; reset restores every default.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_control_reg <= SETUP_RESET;
      scale_factor_reg <= SCALE_RESET;
      alert_select_flags_reg <= ALERT_SEL_RESET;
      alert_threshold_reg <= THRESH_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SETUP: setup_control_reg <= {1'b0, reg_wdata[14:0]};
        ADDR_SCALE: scale_factor_reg <= {1'b0, reg_wdata[14:0]};
        ADDR_ALERT_SEL: begin
          alert_select_flags_reg <= {
            reg_wdata[SHUNT_OVER_EN_BIT:READY_EN_BIT], 10'h000};
        end
        ADDR_THRESH: alert_threshold_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux, registered for a clean one-cycle answer.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SETUP: reg_rdata <= setup_control_reg;
        ADDR_SHUNT: reg_rdata <= shunt_reg;
        ADDR_RAIL: reg_rdata <= rail_reg;
        ADDR_POWER: reg_rdata <= power_reg;
        ADDR_CURRENT: reg_rdata <= current_reg;
        ADDR_SCALE: reg_rdata <= scale_factor_reg;
        ADDR_ALERT_SEL: reg_rdata <= {
          alert_select_flags_reg[SHUNT_OVER_EN_BIT:READY_EN_BIT], 5'h00,
          trip_flag_reg, ready_flag_reg, 3'h0};
        ADDR_THRESH: reg_rdata <= alert_threshold_reg;
      endcase
    end
  end
endmodule

// >>> spm_host_model.sv
// Register host model that drives the monitor's register port.
`timescale 1ns/1ns
module spm_host_model (
  input wire logic clk, // System clock.
  output logic [2:0] reg_addr, // Register index.
  output logic reg_wr, // Write strobe.
  output logic reg_rd, // Read strobe.
  output logic [15:0] reg_wdata, // Write data.
  input wire logic [15:0] reg_rdata // Read data.
);
  // Idle levels at time zero.
  initial begin
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Each task is entered at a falling edge and leaves one idle cycle.
  // The data lines carry the inverse after a write, so a stale word
  // can never pass for a fresh one.
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    @(negedge clk);
  endtask
  // A write followed at once by a read of the same register.
  task automatic wr_rd(input logic [2:0] a, input logic [15:0] d,
    output logic [15:0] q);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_wdata = ~d;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
    @(negedge clk);
  endtask
endmodule

// >>> spm_monitor_assertions.sv
// Checker with concurrent assertions on the monitor's ports.
`timescale 1ns/1ns
module spm_monitor_checker
  import spm_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset.
  input wire logic [2:0] reg_addr, // Register index.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic [15:0] adc_shunt, // Shunt sample.
  input wire logic [15:0] adc_rail, // Rail sample.
  input wire logic alert_n // Alert, active low.
);
  logic ever_en; // Some alert condition was enabled since reset.
  logic cal_ever; // Calibration was made nonzero since reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Remember host writes that may legitimately pull alert or scale results.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ever_en <= 1'b0;
      cal_ever <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_ALERT_SEL && reg_wdata[15:10] != 6'h00)
        ever_en <= 1'b1;
      if (reg_addr == ADDR_SCALE && reg_wdata[14:0] != 15'h0000)
        cal_ever <= 1'b1;
    end
  end
  sequence wr_rd(logic [2:0] a);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
  endsequence
  // Read-back checks mask what the register cannot hold.
  a_setup_rdback: assert property (wr_rd(ADDR_SETUP) |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h7fff))
    else $error("setup read-back wrong");
  a_scale_rdback: assert property (wr_rd(ADDR_SCALE) |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h7fff))
    else $error("calibration read-back wrong");
  a_thresh_rdback: assert property (wr_rd(ADDR_THRESH) |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("threshold read-back wrong");
  a_sel_rdback: assert property (wr_rd(ADDR_ALERT_SEL) |=>
    (reg_rdata & 16'hfc00) == ($past(reg_wdata, 2) & 16'hfc00))
    else $error("alert select read-back wrong");
  a_alert_idle: assert property (!ever_en |-> alert_n)
    else $error("alert without an enabled condition");
  a_uncal_zero: assert property (!cal_ever && reg_rd &&
    (reg_addr == ADDR_POWER || reg_addr == ADDR_CURRENT)
    |=> reg_rdata == 16'h0000)
    else $error("current result without calibration");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_reset_quiet: assert property ($fell(sys_rst) |->
    alert_n && reg_rdata == 16'h0000)
    else $error("outputs not quiet after reset");
  cover property (!alert_n);
  cover property (wr_rd(ADDR_SCALE));
  cover property (reg_rd && reg_addr == ADDR_CURRENT ##1 reg_rdata != 0);
endmodule
bind spm_monitor spm_monitor_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_shunt(adc_shunt),
  .adc_rail(adc_rail), .alert_n(alert_n));

// >>> shunt_power_monitor_regs_bench.sv
// Self-checking bench for the monitor's registers, results and alert.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module shunt_power_monitor_regs_bench import spm_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] adc_shunt = 16'h0000;
  logic [15:0] adc_rail = 16'h0000;
  logic alert_n;
  logic [15:0] v;
  int fail_count = 0;
  int checked = 0;
  // A 10 MHz clock.
  always #50 clk = ~clk;
  spm_monitor dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .adc_shunt(adc_shunt), .adc_rail(adc_rail),
    .alert_n(alert_n));
  spm_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Clear the ready flag first, since it may be left from an old
  // conversion, then count n fresh conversions.
  task automatic wait_conv(input int n);
    int k;
    host.rd(ADDR_ALERT_SEL, v);
    repeat (n) begin
      k = 0;
      v = 16'h0000;
      while (v[READY_FLAG_BIT] !== 1'b1 && k < 3000) begin
        host.rd(ADDR_ALERT_SEL, v);
        k++;
      end
      `CHK("conversion ready", 1'b1, v[READY_FLAG_BIT])
    end
  endtask
  // Every register comes out of reset at its default.
  task automatic t_defaults;
    logic [15:0] dflt [8];
    dflt = '{SETUP_RESET, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      SCALE_RESET, ALERT_SEL_RESET, THRESH_RESET};
    for (int a = 0; a < 8; a++) begin
      host.rd(3'(a), v);
      `CHK("reset value", dflt[a], v)
    end
  endtask
  // Voltages read correctly before calibration; result writes are ignored.
  task automatic t_uncal;
    host.wr_rd(ADDR_SETUP, 16'h4007, v);
    `CHK("setup", 16'h4007, v)
    adc_shunt = 16'h4b00;
    adc_rail = 16'h1d4c;
    wait_conv(2);
    host.wr(ADDR_SHUNT, 16'h1234);
    host.rd(ADDR_SHUNT, v);
    `CHK("shunt", 16'h4b00, v)
    host.rd(ADDR_RAIL, v);
    `CHK("rail", 16'h1d4c, v)
    host.rd(ADDR_POWER, v);
    `CHK("power uncal", 16'h0000, v)
    host.rd(ADDR_CURRENT, v);
    `CHK("current uncal", 16'h0000, v)
  endtask
  // Calibrated current and power, for both signs of shunt voltage.
  task automatic t_cal;
    host.wr_rd(ADDR_SCALE, 16'h8500, v);
    `CHK("scale", 16'h0500, v)
    adc_rail = 16'h1d4c;
    wait_conv(2);
    host.rd(ADDR_CURRENT, v);
    `CHK("current", 16'h2ee0, v)
    host.rd(ADDR_POWER, v);
    `CHK("power", 16'h1194, v)
    adc_shunt = 16'hb500;
    wait_conv(2);
    host.rd(ADDR_CURRENT, v);
    `CHK("neg current", 16'hd120, v)
    host.rd(ADDR_SHUNT, v);
    `CHK("neg shunt", 16'hb500, v)
    host.rd(ADDR_POWER, v);
    `CHK("neg power", 16'h1194, v)
  endtask
  // Alert: signed over-limit, exact limit, under-limit, rail limits, off.
  task automatic t_alert;
    logic [15:0] sh [8];
    logic [15:0] sel [8];
    logic al [8];
    sh = '{16'hb500, 16'h7081, 16'h7080, 16'h7081, 16'h7000, 16'h7000,
      16'h7000, 16'h7081};
    sel = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h4000, 16'h2000,
      16'h1000, 16'h0000};
    al = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    host.wr_rd(ADDR_THRESH, 16'h7080, v);
    `CHK("threshold", 16'h7080, v)
    host.wr_rd(ADDR_ALERT_SEL, 16'h8000, v);
    `CHK("alert select", 16'h8000, v & 16'hfc00)
    for (int i = 0; i < 8; i++) begin
      adc_shunt = sh[i];
      host.wr(ADDR_ALERT_SEL, sel[i]);
      wait_conv(2);
      `CHK("alert", al[i], alert_n)
      host.rd(ADDR_ALERT_SEL, v);
      `CHK("trip flag", ~al[i], v[TRIP_FLAG_BIT])
    end
  endtask
  // A reset in mid-run brings back the defaults.
  task automatic t_reset;
    host.wr(ADDR_THRESH, 16'h1234);
    sys_rst = 1'b1;
    @(negedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    host.rd(ADDR_THRESH, v);
    `CHK("threshold after reset", THRESH_RESET, v)
    host.rd(ADDR_SETUP, v);
    `CHK("setup after reset", SETUP_RESET, v)
    `CHK("alert after reset", 1'b1, alert_n)
  endtask
  // Main sequence after the start-up reset.
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_defaults;
    t_uncal;
    t_cal;
    t_alert;
    t_reset;
    tally_and_finish;
  end
  // Watchdog set well past the roughly 62,000 cycles the tests need.
  initial begin
    #9000000;
    fail_count++;
    tally_and_finish;
  end
endmodule
